//--- logic/parallel_passive_load_defs.vh
// constants for the parallel passive configuration port
`ifndef PARALLEL_PASSIVE_LOAD_DEFS_VH
`define PARALLEL_PASSIVE_LOAD_DEFS_VH

// register byte addresses
`define REG_CONTROL 4'h0
`define REG_LENGTH 4'h4
`define REG_CHECKSUM 4'h8
`define REG_STATUS 4'hc

// control fields
`define CTL_WIDTH_LSB 0
`define CTL_WIDTH_MSB 1
`define CTL_DECOMPRESS 2
`define CTL_DECRYPT 3
`define CTL_USER_CLOCK 4
`define CONTROL_RESET 32'h00000002
`define LENGTH_RESET 32'h00000000
`define CHECKSUM_RESET 32'h00000000

// status fields
`define STA_STATE_LSB 0
`define STA_STATE_MSB 2
`define STA_USER_MODE 3
`define STA_RATIO_LSB 4
`define STA_RATIO_MSB 7
`define STA_CHECK_ERR 8
`define STA_COUNT_LSB 16

// width codes
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2

// timing
`define CLK_PERIOD_PS 4000
`define T_STATUS_MIN_US 268
`define T_USER_MIN_US 175
`define USER_INIT_CLOCKS 8576
`define STATUS_MIN_CYC ((`T_STATUS_MIN_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define USER_MIN_CYC ((`T_USER_MIN_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

//--- logic/parallel_passive_load.v
// parallel passive configuration port, device side
`timescale 1ns/1ps
`include "parallel_passive_load_defs.vh"

module parallel_passive_load #(
	parameter STATUS_MIN_CYC = `STATUS_MIN_CYC,
	parameter USER_MIN_CYC = `USER_MIN_CYC,
	parameter USER_INIT_CLOCKS = `USER_INIT_CLOCKS
) (
	// clock and reset
	input wire clock_in,
	input wire rst_in,
	// avalon-mm slave
	input wire [3:0] address_in,
	input wire read_in,
	input wire write_in,
	input wire [31:0] writedata_in,
	input wire [3:0] byteenable_in,
	output reg [31:0] readdata_out,
	output wire waitrequest_out,
	// configuration pins
	input wire config_clock_in,
	input wire [31:0] config_data_in,
	input wire config_request_n_in,
	input wire config_status_n_in,
	output wire config_status_n_out,
	output wire config_status_n_oe_out,
	input wire config_complete_in,
	output wire config_complete_out,
	output wire config_complete_oe_out,
	input wire user_init_clock_in,
	// image stream and mode
	output reg [31:0] word_out,
	output reg word_valid_out,
	output reg user_mode_out
);

localparam ST_RESET = 3'h0;
localparam ST_STATUS = 3'h1;
localparam ST_LOAD = 3'h2;
localparam ST_TAIL = 3'h3;
localparam ST_INIT = 3'h4;
localparam ST_USER = 3'h5;
localparam ST_ERROR = 3'h6;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg req_s1, req_s2;
reg clk_s1, clk_s2, clk_s3;
reg ucl_s1, ucl_s2, ucl_s3;
reg sta_s1, sta_s2;
reg cmp_s1, cmp_s2;
reg [31:0] dat_s1, dat_s2;

always @(posedge clock_in) begin
	if (rst_in) begin
		req_s1 <= 1'b1;
		req_s2 <= 1'b1;
		clk_s1 <= 1'b0;
		clk_s2 <= 1'b0;
		clk_s3 <= 1'b0;
		ucl_s1 <= 1'b0;
		ucl_s2 <= 1'b0;
		ucl_s3 <= 1'b0;
		sta_s1 <= 1'b0;
		sta_s2 <= 1'b0;
		cmp_s1 <= 1'b0;
		cmp_s2 <= 1'b0;
		dat_s1 <= 32'h00000000;
		dat_s2 <= 32'h00000000;
	end else begin
		req_s1 <= config_request_n_in;
		req_s2 <= req_s1;
		clk_s1 <= config_clock_in;
		clk_s2 <= clk_s1;
		clk_s3 <= clk_s2;
		ucl_s1 <= user_init_clock_in;
		ucl_s2 <= ucl_s1;
		ucl_s3 <= ucl_s2;
		sta_s1 <= config_status_n_in;
		sta_s2 <= sta_s1;
		cmp_s1 <= config_complete_in;
		cmp_s2 <= cmp_s1;
		dat_s1 <= config_data_in;
		dat_s2 <= dat_s1;
	end
end

// rising edges seen on the sampled clocks
wire cfg_rise = clk_s2 & ~clk_s3;
wire ucl_rise = ucl_s2 & ~ucl_s3;

////////////////////////////////////////////////////////////////////////////////
// registers

reg [31:0] control;
reg [31:0] length;
reg [31:0] checksum;
reg ack;
reg [2:0] state;
reg [31:0] count;
reg [31:0] sum;
reg check_err;
reg [31:0] timer;
reg [2:0] phase;
reg [2:0] tail;

wire [1:0] width = control[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB];
wire decompress = control[`CTL_DECOMPRESS];
wire decrypt = control[`CTL_DECRYPT];
wire use_user_clock = control[`CTL_USER_CLOCK];

// clock-to-data ratio by width and features
function [3:0] ratio_of;
	input [1:0] w;
	input dc;
	input en;
	begin
		if (dc) begin
			ratio_of = (w == `WIDTH_8) ? 4'h2 : (w == `WIDTH_16) ? 4'h4 : 4'h8;
		end else if (en) begin
			ratio_of = (w == `WIDTH_8) ? 4'h1 : (w == `WIDTH_16) ? 4'h2 : 4'h4;
		end else begin
			ratio_of = 4'h1;
		end
	end
endfunction

wire [3:0] ratio = ratio_of(width, decompress, decrypt);
wire [2:0] last_phase = ratio[2:0] - 3'h1;

// low lines only for narrow widths
wire [31:0] lane_mask = (width == `WIDTH_8) ? 32'h000000ff :
	(width == `WIDTH_16) ? 32'h0000ffff : 32'hffffffff;
wire [31:0] lane_word = dat_s2 & lane_mask;

wire [31:0] be_mask = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
	{8{byteenable_in[1]}}, {8{byteenable_in[0]}}};

wire [31:0] status_word = {count[15:0], 7'h00, check_err, ratio, user_mode_out, state};

// one wait cycle, then the answer
assign waitrequest_out = (read_in | write_in) & ~ack;

always @(posedge clock_in) begin
	if (rst_in) begin
		ack <= 1'b0;
		readdata_out <= 32'h00000000;
		control <= `CONTROL_RESET;
		length <= `LENGTH_RESET;
		checksum <= `CHECKSUM_RESET;
	end else begin
		ack <= (read_in | write_in) & ~ack;
		// writes land at the edge where waitrequest is low
		if (write_in & ack) begin
			case (address_in)
				`REG_CONTROL: begin
					control <= (control & ~be_mask) | (writedata_in & be_mask);
				end
				`REG_LENGTH: begin
					length <= (length & ~be_mask) | (writedata_in & be_mask);
				end
				`REG_CHECKSUM: begin
					checksum <= (checksum & ~be_mask) | (writedata_in & be_mask);
				end
				default: begin
				end
			endcase
		end
		if (read_in & ~ack) begin
			case (address_in)
				`REG_CONTROL: readdata_out <= {27'h0000000, control[4:0]};
				`REG_LENGTH: readdata_out <= length;
				`REG_CHECKSUM: readdata_out <= checksum;
				`REG_STATUS: readdata_out <= status_word;
				default: readdata_out <= 32'h00000000;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// configuration sequence

always @(posedge clock_in) begin
	if (rst_in) begin
		state <= ST_RESET;
		timer <= 32'h00000000;
		count <= 32'h00000000;
		sum <= 32'h00000000;
		check_err <= 1'b0;
		phase <= 3'h0;
		tail <= 3'h0;
		word_out <= 32'h00000000;
		word_valid_out <= 1'b0;
		user_mode_out <= 1'b0;
	end else begin
		word_valid_out <= 1'b0;
		if (!req_s2) begin
			// request low: restart, status and complete pulled low
			state <= ST_RESET;
			timer <= 32'h00000000;
			count <= 32'h00000000;
			sum <= 32'h00000000;
			check_err <= 1'b0;
			phase <= 3'h0;
			user_mode_out <= 1'b0;
		end else begin
			case (state)
				ST_RESET: begin
					timer <= 32'h00000001;
					state <= ST_STATUS;
				end
				ST_STATUS: begin
					// hold status low the minimum pulse, then wait for the line
					if (timer < STATUS_MIN_CYC) begin
						timer <= timer + 32'h00000001;
					end else if (sta_s2) begin
						state <= ST_LOAD;
						phase <= 3'h0;
					end
				end
				ST_LOAD: begin
					if (cfg_rise) begin
						phase <= (phase == last_phase) ? 3'h0 : phase + 3'h1;
						if (phase == 3'h0) begin
							word_out <= lane_word;
							word_valid_out <= 1'b1;
							sum <= sum + lane_word;
							count <= count + 32'h00000001;
							if (count + 32'h00000001 >= length) begin
								tail <= last_phase;
								state <= ST_TAIL;
							end
						end
					end
				end
				ST_TAIL: begin
					// device uses the trailing clocks to finish processing
					if (tail == 3'h0) begin
						timer <= 32'h00000000;
						if (sum == checksum) begin
							state <= ST_INIT;
						end else begin
							check_err <= 1'b1;
							state <= ST_ERROR;
						end
					end else if (cfg_rise) begin
						tail <= tail - 3'h1;
					end
				end
				ST_INIT: begin
					if (cmp_s2) begin
						if (use_user_clock) begin
							if (ucl_rise) begin
								timer <= timer + 32'h00000001;
							end
							if (timer >= USER_INIT_CLOCKS) begin
								state <= ST_USER;
								user_mode_out <= 1'b1;
							end
						end else begin
							timer <= timer + 32'h00000001;
							if (timer >= USER_MIN_CYC) begin
								state <= ST_USER;
								user_mode_out <= 1'b1;
							end
						end
					end
				end
				ST_USER: begin
					user_mode_out <= 1'b1;
				end
				ST_ERROR: begin
					user_mode_out <= 1'b0;
				end
				default: begin
					state <= ST_RESET;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// open-drain pins: drive low or release

assign config_status_n_out = 1'b0;
assign config_status_n_oe_out = (state == ST_RESET) | (state == ST_STATUS & timer < STATUS_MIN_CYC) |
	(state == ST_ERROR);
assign config_complete_out = 1'b0;
assign config_complete_oe_out = ~((state == ST_INIT) | (state == ST_USER));

endmodule // parallel_passive_load

//--- dv/parallel_passive_load_checker.sv
// assertions on the configuration port pins
`timescale 1ns/1ps
module parallel_passive_load_checker #(parameter STATUS_MIN_CYC = 20, parameter USER_MIN_CYC = 20) (
	input wire clock_in, rst_in, config_clock_in, config_request_n_in, config_complete_in,
	input wire config_status_n_oe_out, config_complete_oe_out, word_valid_out, user_mode_out
);
	localparam int LIM = 200;
	int unsigned st_cnt, cd_cnt;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// length of status pulse and of complete high
	always @(posedge clock_in) begin
		st_cnt <= (rst_in || !config_status_n_oe_out) ? 0 : st_cnt + 1;
		cd_cnt <= (rst_in || !config_complete_in) ? 0 : cd_cnt + 1;
	end
	sequence s_both_low; config_status_n_oe_out && config_complete_oe_out; endsequence
	property p_edge; word_valid_out |-> $past(config_clock_in, 2); endproperty
	property p_req; $fell(config_request_n_in) |-> ##[1:150] s_both_low; endproperty
	property p_hold; (!config_request_n_in)[*8] |-> s_both_low and !user_mode_out; endproperty
	property p_pulse; $fell(config_status_n_oe_out) |-> st_cnt >= STATUS_MIN_CYC; endproperty
	property p_rel; $rose(config_request_n_in) |-> ##[1:LIM] !config_status_n_oe_out; endproperty
	property p_load; word_valid_out |-> config_complete_oe_out; endproperty
	property p_entry; $rose(user_mode_out) |-> cd_cnt >= USER_MIN_CYC; endproperty
	property p_user; user_mode_out |-> config_complete_in && !config_status_n_oe_out; endproperty
	a_edge: assert property (p_edge) else $error("word without clock edge");
	a_req: assert property (p_req) else $error("pins not pulled low");
	a_hold: assert property (p_hold) else $error("pins released in request");
	a_pulse: assert property (p_pulse) else $error("status pulse short");
	a_rel: assert property (p_rel) else $error("status not released");
	a_load: assert property (p_load) else $error("complete high in load");
	a_entry: assert property (p_entry) else $error("user mode early");
	a_user: assert property (p_user) else $error("user mode with pins low");
endmodule // parallel_passive_load_checker
bind parallel_passive_load parallel_passive_load_checker #(.STATUS_MIN_CYC(STATUS_MIN_CYC),
	.USER_MIN_CYC(USER_MIN_CYC)) i_chk (.*);

//--- dv/cfg_host.sv
// host model driving the configuration pins
`timescale 1ns/1ps
module cfg_host (
	input wire logic status_in,
	input wire logic complete_in,
	output logic clk_out,
	output logic [31:0] data_out,
	output logic req_n_out,
	output logic uclk_out
);
	initial begin
		clk_out = 0;
		data_out = 0;
		req_n_out = 1;
		uclk_out = 0;
	end
	task automatic load(input int r, input logic [31:0] m, input logic [31:0] img[$], input bit u);
		#1 req_n_out = 0;
		#2100 req_n_out = 1;
		repeat (3000) if (!status_in) #4;
		#2100;
		foreach (img[i]) begin
			data_out = (img[i] & m) | (~m & $urandom);
			repeat (r) begin
				#10.5 clk_out = 1;
				#52 clk_out = 0;
				#62.5;
			end
			data_out = ~data_out;
		end
		if (u) begin
			repeat (3000) if (!complete_in) #4;
			#500.5;
			repeat (20) begin
				#50 uclk_out = 1;
				#50 uclk_out = 0;
			end
		end
	endtask
endmodule // cfg_host

//--- dv/tb_top.sv
// self-checking bench for the configuration port
`timescale 1ns/1ps
module tb_top;
	logic clock_in = 0, rst_in = 1, read_in = 0, write_in = 0;
	logic [3:0] address_in = 0;
	logic [31:0] writedata_in = 0, readdata_out, word_out, q, config_data_in;
	logic waitrequest_out, word_valid_out, user_mode_out, config_clock_in, config_request_n_in, user_init_clock_in;
	logic config_status_n_oe_out, config_complete_oe_out, config_status_n_in, config_complete_in;
	logic config_status_n_out, config_complete_out;
	logic [31:0] got[$], img[$];
	int err_count = 0, num_checks = 0;
	assign config_status_n_in = config_status_n_oe_out ? config_status_n_out : 1'b1;
	assign config_complete_in = config_complete_oe_out ? config_complete_out : 1'b1;
	initial forever #2 clock_in = ~clock_in;
	parallel_passive_load #(.STATUS_MIN_CYC(20), .USER_MIN_CYC(20), .USER_INIT_CLOCKS(8)) i_parallel_passive_load (
		.*, .byteenable_in(4'hf));
	cfg_host i_cfg_host (.status_in(config_status_n_in), .complete_in(config_complete_in),
		.clk_out(config_clock_in), .data_out(config_data_in), .req_n_out(config_request_n_in),
		.uclk_out(user_init_clock_in));
	always @(posedge clock_in) if (word_valid_out === 1'b1) got.push_back(word_out);
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_in);
		address_in <= a;
		read_in <= !wr;
		write_in <= wr;
		writedata_in <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clock_in);
			if (waitrequest_out === 1'b0) break;
		end
		q = readdata_out;
		read_in <= 0;
		write_in <= 0;
		if (n == 20) begin
			err_count++;
			summarize();
		end
	endtask
	function automatic int ratio(int w, dc, de);
		return dc ? 2 << w : de ? 1 << w : 1;
	endfunction
	////////////////////////////////////////
	initial begin
		#390000 err_count++;
		summarize();
	end
	initial begin
		int w, dc, de, u, n, bad, k;
		logic [31:0] sum, m;
		void'($urandom(32'h7172));
		repeat (20) @(posedge clock_in);
		rst_in <= 0;
		bus(0, 4'h0, 0);
		check("control reset", q, 32'h00000002);
		bus(0, 4'h2, 0);
		check("unmapped read", q, 0);
		for (int t = 0; t < 13; t++) begin
			w = t % 3;
			dc = t / 3 % 2;
			de = t / 6 % 2;
			bad = t == 12;
			u = bad ? 0 : $urandom % 2;
			m = w == 0 ? 32'h000000ff : w == 1 ? 32'h0000ffff : 32'hffffffff;
			n = 1 + $urandom % 4;
			img = {};
			got = {};
			sum = 0;
			repeat (n) begin
				img.push_back($urandom);
				sum += img[$] & m;
			end
			bus(1, 4'h0, 32'(u * 16 + de * 8 + dc * 4 + w));
			bus(1, 4'h4, 32'(n));
			bus(1, 4'h8, sum + 32'(bad));
			bus(0, 4'h4, 0);
			check("length", q, n);
			bus(0, 4'hc, 0);
			check("ratio", 32'(q[7:4]), ratio(w, dc, de));
			i_cfg_host.load(ratio(w, dc, de), m, img, u);
			check("word count", got.size(), n);
			foreach (img[i]) check("word", got[i], img[i] & m);
			for (k = 0; k < 3000 && user_mode_out !== 1'b1; k++) @(posedge clock_in);
			check("user mode", user_mode_out, !bad);
			bus(0, 4'hc, 0);
			check("check error", q[8], bad);
			$display("test %0d done", t);
		end
		summarize();
	end
endmodule // tb_top
